// File: hdl/fqs_ctrl.sv
// flash controller read path, burst mapping and bus wait control
`timescale 1ns/1ns
`default_nettype none
module fqs_ctrl #(
	parameter logic [7:0] DIV_HALF = 8'h02, // clocks per serial half period
	parameter logic [7:0] READ_CMD = 8'h03  // auto read instruction
) (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        sys_rst_in,
	// ahb slave
	input  wire logic        hsel_reg_in,
	input  wire logic        hsel_flash_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [31:0] hwdata_in,
	output logic [31:0]      hrdata_out,
	output logic             hready_out,
	output logic             hresp_out,
	// serial flash pins
	output logic             flash_cs_n_out,
	output logic             flash_sck_out,
	output logic             flash_mosi_out,
	input  wire logic        flash_miso_in
);
	import fqs_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [MODE_W-1:0] mode;      // flash_mode_control
		fqs_state_t        st;        // engine state
		fqs_op_t           op;        // current operation
		logic              hready;    // bus ready
		logic [31:0]       hrdata;    // bus read data
		logic              dp_wr;     // write data phase pending
		logic [31:0]       dp_addr;   // address of pending write
		logic              waiting;   // bus stalled on engine
		logic              sck;       // serial clock
		logic              cs_n;      // chip select, active low
		logic              mosi;      // serial out
		logic [7:0]        div;       // half period counter
		logic [5:0]        clk_left;  // clocks left in phase
		logic [31:0]       tx;        // transmit shifter
		logic [31:0]       rx;        // receive shifter
		logic [5:0]        rx_cnt;    // bits received
		logic [31:0]       recv;      // last received word
		logic [31:0]       next_addr; // next sequential beat
		logic [23:0]       start_addr;// address for new command
		logic              sync1;     // input synchroniser stage 1
		logic              sync2;     // input synchroniser stage 2
	} fqs_state_reg_t;
	fqs_state_reg_t s_reg;
	fqs_state_reg_t s_next;

	logic     take;       // address phase accepted
	logic     flash_take; // read of flash window
	logic     cont_take;  // sequential beat continues the burst
	logic     x_rise;     // rising edge in receive phase
	logic     x_fall;     // falling edge in receive phase
	logic     samp;       // selected sample strobe
	logic     samp_bit;   // selected sample data
	logic     drain_done; // word fully received
	logic     busy;       // transfer_busy_flag
	logic     start_man;  // start a manual transfer
	fqs_op_t  start_op;   // its operation
	logic [31:0] start_word; // its transmit word
	logic     p_stb;      // read pipe strobe
	logic     p_dat;      // read pipe data

	wire logic auto_md = s_reg.mode[MODE_AUTO_BIT];
	wire logic split   = s_reg.mode[MODE_SPLIT_BIT];
	wire logic pipe_en = s_reg.mode[MODE_PIPE_BIT];
	wire logic edge_ng = s_reg.mode[MODE_EDGE_BIT];
	wire logic no_wait = s_reg.mode[MODE_NOWAIT_BIT];
	wire logic [DLY_W-1:0] dly = s_reg.mode[MODE_DLY_MSB:MODE_DLY_LSB];

	// address hits one of the manual data registers
	function automatic logic is_man_data(input logic [31:0] a);
		is_man_data = (a == ADDR_WDATA) || (a == ADDR_RDATA) ||
			(a == ADDR_DUMMY);
	endfunction

	// ==========================================================
	// read pipe: delays falling-edge samples by the chosen steps
	fqs_read_pipe #(.DEPTH(8)) u_pipe (
		.clock_in     (clock_in),
		.sys_rst_in   (sys_rst_in),
		.strobe_in    (x_fall),
		.data_in      (s_reg.sync2),
		.delay_sel_in (dly),
		.strobe_out   (p_stb),
		.data_out     (p_dat)
	);

	// ==========================================================
	// next state
	always_comb begin
		s_next     = s_reg;
		x_rise     = 1'b0;
		x_fall     = 1'b0;
		drain_done = 1'b0;
		start_man  = 1'b0;
		start_op   = OP_WRITE;
		start_word = WORD_ZERO;
		busy = (s_reg.st != ST_IDLE) && (s_reg.st != ST_HOLD);
		take = s_reg.hready && htrans_in[1] &&
			(hsel_reg_in || hsel_flash_in);
		flash_take = take && hsel_flash_in && !hwrite_in;
		cont_take = flash_take && auto_md && !split &&
			(s_reg.st == ST_HOLD) && (htrans_in == HTRANS_SEQ) &&
			(haddr_in == s_reg.next_addr);
		// only the second stage is read by logic
		s_next.sync1 = flash_miso_in;
		s_next.sync2 = s_reg.sync1;

		// serial clock: toggles only while a phase is shifting
		if ((s_reg.st == ST_ADDR) || (s_reg.st == ST_XFER)) begin
			if (s_reg.div == DIV_HALF - 8'h01) begin
				s_next.div = 8'h00;
				s_next.sck = ~s_reg.sck;
				if (!s_reg.sck) begin
					// rising edge
					x_rise = (s_reg.st == ST_XFER);
				end else begin
					// falling edge: shift out or end the phase
					x_fall = (s_reg.st == ST_XFER);
					if (s_reg.clk_left == LAST_CLOCK) begin
						s_next.mosi = 1'b0;
						if (s_reg.st == ST_ADDR) begin
							s_next.st       = ST_XFER;
							s_next.clk_left = WORD_CLOCKS;
							s_next.rx_cnt   = 6'h00;
						end else if ((s_reg.op == OP_FLASH) ||
							(s_reg.op == OP_READ)) begin
							s_next.st = ST_DRAIN;
						end else begin
							s_next.st   = ST_IDLE;
							s_next.cs_n = 1'b1;
							if (s_reg.waiting) begin
								s_next.hready  = 1'b1;
								s_next.waiting = 1'b0;
							end
						end
					end else begin
						s_next.clk_left = s_reg.clk_left - 6'h01;
						s_next.tx       = {s_reg.tx[30:0], 1'b0};
						s_next.mosi     = s_reg.tx[30];
					end
				end
			end else begin
				s_next.div = s_reg.div + 8'h01;
			end
		end
		// write and dummy words never sample
		if ((s_reg.op == OP_WRITE) || (s_reg.op == OP_DUMMY)) begin
			x_rise = 1'b0;
			x_fall = 1'b0;
		end

		// sample selection: pipe, else the chosen edge
		if (pipe_en) begin
			samp     = p_stb;
			samp_bit = p_dat;
		end else begin
			samp     = edge_ng ? x_fall : x_rise;
			samp_bit = s_reg.sync2;
		end
		if (samp && (s_reg.rx_cnt != WORD_CLOCKS)) begin
			s_next.rx     = {s_reg.rx[30:0], samp_bit};
			s_next.rx_cnt = s_reg.rx_cnt + 6'h01;
		end

		// drain: delayed samples may arrive after the last edge
		if ((s_reg.st == ST_DRAIN) && (s_reg.rx_cnt == WORD_CLOCKS)) begin
			drain_done  = 1'b1;
			s_next.recv = s_reg.rx;
			if (s_reg.waiting) begin
				s_next.hready  = 1'b1;
				s_next.hrdata  = s_reg.rx;
				s_next.waiting = 1'b0;
			end
			if ((s_reg.op == OP_FLASH) && !split) begin
				s_next.st = ST_HOLD;
			end else begin
				s_next.st   = ST_IDLE;
				s_next.cs_n = 1'b1;
			end
		end

		// gap: chip select high one cycle, then command and address
		if (s_reg.st == ST_GAP) begin
			s_next.st       = ST_ADDR;
			s_next.cs_n     = 1'b0;
			s_next.tx       = {READ_CMD, s_reg.start_addr};
			s_next.mosi     = READ_CMD[7];
			s_next.clk_left = WORD_CLOCKS;
			s_next.div      = 8'h00;
			s_next.sck      = 1'b0;
		end

		// a held burst ends on anything but the next beat
		if ((s_reg.st == ST_HOLD) && s_reg.hready && !cont_take) begin
			s_next.st   = ST_IDLE;
			s_next.cs_n = 1'b1;
		end

		// write data phase
		if (s_reg.dp_wr) begin
			s_next.dp_wr = 1'b0;
			if (s_reg.dp_addr == ADDR_MODE) begin
				s_next.mode = hwdata_in[MODE_W-1:0];
			end else if (is_man_data(s_reg.dp_addr) && !auto_md &&
				!busy) begin
				start_man  = 1'b1;
				start_op   = (s_reg.dp_addr == ADDR_DUMMY) ?
					OP_DUMMY : OP_WRITE;
				start_word = (s_reg.dp_addr == ADDR_DUMMY) ?
					WORD_ZERO : hwdata_in;
			end else if (s_reg.waiting) begin
				// refused while busy: release the bus
				s_next.hready  = 1'b1;
				s_next.waiting = 1'b0;
			end
		end

		// address phase
		if (take) begin
			s_next.hrdata = WORD_ZERO;
			if (flash_take) begin
				if (auto_md) begin
					s_next.hready     = 1'b0;
					s_next.waiting    = 1'b1;
					s_next.op         = OP_FLASH;
					s_next.start_addr = haddr_in[23:0];
					s_next.next_addr  = haddr_in + BEAT_BYTES;
					if (cont_take) begin
						s_next.st       = ST_XFER;
						s_next.clk_left = WORD_CLOCKS;
						s_next.rx_cnt   = 6'h00;
						s_next.div      = 8'h00;
					end else begin
						s_next.st   = ST_GAP;
						s_next.cs_n = 1'b1;
					end
				end
			end else if (hsel_reg_in && hwrite_in) begin
				s_next.dp_wr   = 1'b1;
				s_next.dp_addr = haddr_in;
				if (is_man_data(haddr_in) && !auto_md && !no_wait &&
					(haddr_in != ADDR_RDATA)) begin
					s_next.hready  = 1'b0;
					s_next.waiting = 1'b1;
				end
			end else if (hsel_reg_in) begin
				if (haddr_in == ADDR_MODE) begin
					s_next.hrdata = {MODE_PAD, s_reg.mode};
				end else if (haddr_in == ADDR_STATUS) begin
					s_next.hrdata = {STATUS_PAD, busy};
				end else if ((haddr_in == ADDR_RECV) ||
					(haddr_in == ADDR_RDATA)) begin
					s_next.hrdata = s_reg.recv;
				end
				if ((haddr_in == ADDR_RDATA) && !auto_md && !busy) begin
					start_man = 1'b1;
					start_op  = OP_READ;
					if (!no_wait) begin
						s_next.hready  = 1'b0;
						s_next.waiting = 1'b1;
					end
				end
			end
		end

		// launch a manual word: chip select low for its duration
		if (start_man) begin
			s_next.st       = ST_XFER;
			s_next.op       = start_op;
			s_next.cs_n     = 1'b0;
			s_next.tx       = start_word;
			s_next.mosi     = start_word[31];
			s_next.clk_left = WORD_CLOCKS;
			s_next.rx_cnt   = 6'h00;
			s_next.div      = 8'h00;
			s_next.sck      = 1'b0;
		end
	end

	// register the state
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_reg         <= '0;
			s_reg.mode    <= MODE_RESET;
			s_reg.st      <= ST_IDLE;
			s_reg.op      <= OP_FLASH;
			s_reg.hready  <= 1'b1;
			s_reg.cs_n    <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata_out     = s_reg.hrdata;
	assign hready_out     = s_reg.hready;
	assign hresp_out      = 1'b0 & s_reg.hready;
	assign flash_cs_n_out = s_reg.cs_n;
	assign flash_sck_out  = s_reg.sck;
	assign flash_mosi_out = s_reg.mosi;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_restart;
		(s_reg.st == ST_GAP) && s_reg.cs_n ##1
		(s_reg.st == ST_ADDR) && !s_reg.cs_n;
	endsequence

	a_burst_hold_cs: assert property (drain_done && s_reg.op == OP_FLASH &&
		!split |=> !flash_cs_n_out && s_reg.st == ST_HOLD)
		else $error("unsplit burst dropped chip select");
	a_burst_no_cmd: assert property (cont_take |=>
		s_reg.st == ST_XFER && !flash_cs_n_out)
		else $error("sequential beat sent a new command");
	a_split_restart: assert property (flash_take && auto_md &&
		!cont_take |=> s_restart)
		else $error("beat without full command sequence");
	a_split_cs_rel: assert property (drain_done && split |=>
		flash_cs_n_out)
		else $error("split beat kept chip select low");
	a_pipe_delay_min: assert property (x_fall && dly == 3'h0 |->
		##2 p_stb)
		else $error("read pipe delay zero not two cycles");
	a_pipe_select: assert property (pipe_en && x_rise && !p_stb |=>
		s_reg.rx_cnt == $past(s_reg.rx_cnt))
		else $error("pipe enabled but edge sample used");
	a_edge_rise: assert property (!pipe_en && !edge_ng && x_rise &&
		s_reg.rx_cnt != WORD_CLOCKS |=>
		s_reg.rx_cnt == $past(s_reg.rx_cnt) + 6'h01)
		else $error("rising edge sample expected");
	a_edge_fall: assert property (!pipe_en && edge_ng && x_fall &&
		s_reg.rx_cnt != WORD_CLOCKS |=>
		s_reg.rx_cnt == $past(s_reg.rx_cnt) + 6'h01)
		else $error("falling edge sample expected");
	a_wait_manual: assert property (take && hsel_reg_in &&
		is_man_data(haddr_in) && !auto_md && !no_wait && !busy |=>
		!hready_out)
		else $error("manual data access not stalled");
	a_nowait_manual: assert property (take && hsel_reg_in &&
		is_man_data(haddr_in) && no_wait |=> hready_out)
		else $error("wait state with no-wait select set");
	a_auto_wait: assert property (flash_take && auto_md |=>
		!hready_out)
		else $error("auto mode access without wait state");
	a_manual_flash: assert property (flash_take && !auto_md |=>
		hready_out && s_reg.st != ST_GAP)
		else $error("flash read started in manual mode");
endmodule // fqs_ctrl
`default_nettype wire

// File: hdl/fqs_pkg.sv
// constants and types for the flash read path and bus wait control
package fqs_pkg;
	// ==========================================================
	// register byte addresses
	localparam logic [31:0] ADDR_RECV   = 32'h0c000008; // received data
	localparam logic [31:0] ADDR_MODE   = 32'h0c000004; // flash_mode_control
	localparam logic [31:0] ADDR_STATUS = 32'h0c000014; // controller_status
	localparam logic [31:0] ADDR_WDATA  = 32'h0c000018; // manual_write_data
	localparam logic [31:0] ADDR_RDATA  = 32'h0c00001c; // manual_read_data
	localparam logic [31:0] ADDR_DUMMY  = 32'h0c000020; // manual_dummy_clocks

	// ==========================================================
	// flash_mode_control layout
	localparam int          MODE_W          = 14;       // stored bits
	localparam logic [13:0] MODE_RESET      = 14'h0000; // all fields clear
	localparam logic [17:0] MODE_PAD        = 18'h00000; // reserved bits
	localparam int          MODE_SPLIT_BIT  = 12;       // burst_split_enable
	localparam int          MODE_DLY_MSB    = 11;       // read_pipe_delay_sel
	localparam int          MODE_DLY_LSB    = 9;
	localparam int          MODE_PIPE_BIT   = 8;        // read_pipe_enable
	localparam int          MODE_EDGE_BIT   = 7;        // sample_edge_select
	localparam int          MODE_NOWAIT_BIT = 6;        // no_wait_state_select
	localparam int          MODE_AUTO_BIT   = 0;        // auto_mode_select
	localparam int          DLY_W           = 3;        // delay field width
	localparam logic [30:0] STATUS_PAD      = 31'h00000000;

	// ==========================================================
	// serial sequence constants
	localparam logic [5:0]  WORD_CLOCKS = 6'h20;  // clocks per word
	localparam logic [5:0]  LAST_CLOCK  = 6'h01;  // final falling edge
	localparam logic [31:0] BEAT_BYTES  = 32'h00000004; // word beat step
	localparam logic [1:0]  HTRANS_SEQ  = 2'h3;   // sequential beat
	localparam logic [31:0] WORD_ZERO   = 32'h00000000;

	// engine operations and states
	typedef enum logic [1:0] {
		OP_FLASH, OP_WRITE, OP_READ, OP_DUMMY
	} fqs_op_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_GAP, ST_ADDR, ST_XFER, ST_DRAIN, ST_HOLD
	} fqs_state_t;
endpackage

// File: hdl/fqs_read_pipe.sv
// read pipe register with programmable sampling delay
`timescale 1ns/1ns
`default_nettype none
module fqs_read_pipe #(
	parameter int DEPTH = 8 // one stage per delay step
) (
	// clock and reset
	input  wire logic                     clock_in,
	input  wire logic                     sys_rst_in,
	// sample strobe and data from the falling serial edge
	input  wire logic                     strobe_in,
	input  wire logic                     data_in,
	input  wire logic [fqs_pkg::DLY_W-1:0] delay_sel_in,
	// delayed sample
	output logic                          strobe_out,
	output logic                          data_out
);
	import fqs_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [DEPTH-1:0] stb;  // strobe delay line
		logic [DEPTH-1:0] dat;  // data delay line
		logic             so;   // tapped strobe
		logic             sd;   // tapped data
	} fqs_pipe_t;
	fqs_pipe_t s_reg;
	fqs_pipe_t s_next;

	// shift both lines and take the selected tap
	always_comb begin
		s_next     = s_reg;
		s_next.stb = {s_reg.stb[DEPTH-2:0], strobe_in};
		s_next.dat = {s_reg.dat[DEPTH-2:0], data_in};
		s_next.so  = s_reg.stb[delay_sel_in];
		s_next.sd  = s_reg.dat[delay_sel_in];
	end

	// register the state
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign strobe_out = s_reg.so;
	assign data_out   = s_reg.sd;
endmodule // fqs_read_pipe
`default_nettype wire

// File: testbench/fqs_flash_model.sv
// behavioural single-lane serial flash on the far side of the controller
`timescale 1ns/1ns
`default_nettype none
module fqs_flash_model (
	// serial pins from the controller
	input  wire logic        cs_n_in,
	input  wire logic        sck_in,
	input  wire logic        mosi_in,
	output logic             miso_out,
	// observation for the bench
	output logic [31:0]      cmd_word_out, // first 32 bits of a frame
	output logic [31:0]      rises_out,    // selected rising edges
	output logic [31:0]      opens_out     // chip select assertions
);
	logic [31:0] idx; // bit index within the frame

	// =========================================================
	// bit served at frame index n
	// command phase bits alternate so a stale line never matches
	function automatic logic bit_at(input logic [31:0] n);
		logic [31:0] a;
		logic [31:0] w;
		a = {8'h00, cmd_word_out[23:0]} + ((n - 32'h20) >> 5) * 32'h4;
		w = {a[15:0], ~a[15:0]};
		if (n < 32'h20)
			return ~(n[0] ^ opens_out[0]);
		return w[5'h1f - 5'((n - 32'h20) & 32'h1f)];
	endfunction

	initial begin
		miso_out = 1'b0;
		cmd_word_out = 32'h0;
		rises_out = 32'h0;
		opens_out = 32'h0;
		idx = 32'h0;
	end

	// released line toggles while deselected, never holds a value
	always #7 if (cs_n_in !== 1'b0) miso_out = ~miso_out;

	// new frame: first bit out shortly after select
	always @(negedge cs_n_in) begin
		opens_out = opens_out + 32'h1;
		idx = 32'h0;
		#5 miso_out = bit_at(32'h0);
	end

	// mode 0: capture on rise, shift out after fall
	always @(posedge sck_in) if (cs_n_in === 1'b0) begin
		if (idx < 32'h20) cmd_word_out = {cmd_word_out[30:0], mosi_in};
		idx = idx + 32'h1;
		rises_out = rises_out + 32'h1;
	end
	always @(negedge sck_in) if (cs_n_in === 1'b0) #5 miso_out = bit_at(idx);
endmodule // fqs_flash_model
`default_nettype wire

// File: testbench/test_fqs_ctrl.sv
// self-checking bench for the flash read path and bus wait control
`timescale 1ns/1ns
`default_nettype none
module test_fqs_ctrl;
	import fqs_pkg::*;
	// =========================================================
	// stimulus and observed nets
	logic        clock_in = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        hsel_reg_in = 1'b0;
	logic        hsel_flash_in = 1'b0;
	logic [31:0] haddr_in = 32'h0;
	logic [1:0]  htrans_in = 2'h0;
	logic        hwrite_in = 1'b0;
	logic [31:0] hwdata_in = 32'h0;
	logic [31:0] hrdata_out;
	logic        hready_out, hresp_out;
	logic        flash_cs_n_out, flash_sck_out, flash_mosi_out;
	logic        flash_miso_in;
	logic [31:0] cmd_word, rises, opens;
	int          mismatches = 0;
	int          total_checks = 0;
	int          waits;          // wait states of the last transfer
	logic [31:0] rd [4];         // read data per beat
	logic [31:0] mode_m;         // model of the mode register

	always #10 clock_in = ~clock_in;

	fqs_ctrl #(.DIV_HALF(8'h02), .READ_CMD(8'h03)) u_dut (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.hsel_reg_in(hsel_reg_in), .hsel_flash_in(hsel_flash_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
		.hrdata_out(hrdata_out), .hready_out(hready_out),
		.hresp_out(hresp_out), .flash_cs_n_out(flash_cs_n_out),
		.flash_sck_out(flash_sck_out), .flash_mosi_out(flash_mosi_out),
		.flash_miso_in(flash_miso_in));
	fqs_flash_model u_flash (
		.cs_n_in(flash_cs_n_out), .sck_in(flash_sck_out),
		.mosi_in(flash_mosi_out), .miso_out(flash_miso_in),
		.cmd_word_out(cmd_word), .rises_out(rises), .opens_out(opens));

	// =========================================================
	// helpers
	function automatic logic [31:0] fword(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	// manual receive pattern follows the frame parity of the flash
	function automatic logic [31:0] manexp();
		return opens[0] ? 32'h55555555 : 32'haaaaaaaa;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// pipelined bus transfer of n beats; next address rides the data phase
	task automatic xfer(input logic fl, wr, input logic [31:0] a, wd,
			input int n);
		int i, guard;
		waits = 0;
		@(negedge clock_in);
		hsel_reg_in = !fl;
		hsel_flash_in = fl;
		hwrite_in = wr;
		haddr_in = a;
		htrans_in = 2'h2;
		@(negedge clock_in);
		for (i = 0; i < n; i++) begin
			hwdata_in = wd;
			if (i < n - 1) begin
				haddr_in = a + BEAT_BYTES * (i + 1);
				htrans_in = HTRANS_SEQ;
			end else begin
				htrans_in = 2'h0;
				hsel_reg_in = 1'b0;
				hsel_flash_in = 1'b0;
			end
			guard = 0;
			// address and data held until the answer edge
			while (hready_out !== 1'b1 && guard < 5000) begin
				@(negedge clock_in);
				waits++;
				guard++;
			end
			// a transfer that never completes counts against the run
			if (guard >= 5000)
				mismatches++;
			rd[i] = hrdata_out;
			@(negedge clock_in);
		end
	endtask

	task automatic wreg(input logic [31:0] a, d);
		xfer(1'b0, 1'b1, a, d, 1);
	endtask
	task automatic rreg(input logic [31:0] a);
		xfer(1'b0, 1'b0, a, 32'h0, 1);
	endtask

	// poll busy: first read still busy, bounded wait for clear
	task automatic poll();
		int g;
		rreg(ADDR_STATUS);
		check("busy set", rd[0], {STATUS_PAD, 1'b1});
		for (g = 0; g < 300 && rd[0][0] !== 1'b0; g++) rreg(ADDR_STATUS);
		check("busy clear", rd[0], {STATUS_PAD, 1'b0});
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// watchdog: whole run is far below this span
	initial begin
		#2000000;
		mismatches++;
		test_done();
	end

	// =========================================================
	// main sequence
	initial begin
		logic [31:0] v, a;
		int k, r0, o0, sp, i;
		v = $urandom(61461);
		repeat (16) @(negedge clock_in);
		sys_rst_in = 1'b0;
		// register reset value, storage, reserved bits, unmapped
		rreg(ADDR_MODE);
		check("mode reset", rd[0], {MODE_PAD, MODE_RESET});
		v = $urandom();
		wreg(ADDR_MODE, v);
		mode_m = {MODE_PAD, v[13:0]};
		rreg(ADDR_MODE);
		check("mode rw", rd[0], mode_m);
		rreg(32'h0c000030);
		check("unmapped", rd[0], WORD_ZERO);
		$display("test registers done");
		// manual data registers with wait states on, then off
		for (k = 0; k < 2; k++) begin
			wreg(ADDR_MODE, k ? 32'h000000c0 : 32'h00000080);
			r0 = rises;
			v = $urandom();
			wreg(ADDR_WDATA, v);
			check("hresp", {31'h0, hresp_out}, 32'h0);
			if (k == 0) check("wr stall", 32'(waits >= 128), 32'h1);
			else begin
				check("wr nowait", 32'(waits), 32'h0);
				poll();
			end
			check("wr word", cmd_word, v);
			check("wr clocks", rises - r0, 32'h20);
			wreg(ADDR_DUMMY, 32'h0);
			if (k == 0) check("dmy stall", 32'(waits > 60), 32'h1);
			else begin
				check("dmy nowait", 32'(waits), 32'h0);
				poll();
			end
			xfer(1'b0, 1'b0, ADDR_RDATA, 32'h0, 1);
			if (k == 0) check("rd word", rd[0], manexp());
			else begin
				check("rd nowait", 32'(waits), 32'h0);
				poll();
			end
			rreg(ADDR_RECV);
			check("recv word", rd[0], manexp());
		end
		$display("test manual done");
		// auto mode refuses manual data accesses
		wreg(ADDR_MODE, 32'h00000081);
		r0 = rises;
		wreg(ADDR_WDATA, $urandom());
		check("auto refuse", rises - r0, 32'h0);
		// auto bursts over every sampling setting, split and unsplit
		for (k = 0; k < 10; k++) begin
			sp = k % 2;
			v = 32'h1 | (k[1] ? 32'h40 : 32'h0) | (sp ? 32'h1000 : 32'h0);
			if (k < 8) v = v | 32'h100 | (k << 9);
			else if (k == 8) v = v | 32'h80;
			wreg(ADDR_MODE, v);
			a = $urandom() & 32'h00fffff0;
			o0 = opens;
			r0 = rises;
			xfer(1'b1, 1'b0, a, 32'h0, 4);
			check("auto stall", 32'(waits > 100), 32'h1);
			check("frames", opens - o0, sp ? 32'h4 : 32'h1);
			check("clocks", rises - r0, sp ? 32'h100 : 32'ha0);
			check("cmd", cmd_word,
				{8'h03, 24'(a + (sp ? 32'hc : 32'h0))});
			check("cs idle", {31'h0, flash_cs_n_out}, 32'h1);
			// rising sample timing hinges on sync latency, not compared
			if (k < 9)
				for (i = 0; i < 4; i++)
					check("beat", rd[i], fword(a + 4 * i));
		end
		$display("test auto done");
		// flash window in manual mode answers zero at once
		wreg(ADDR_MODE, 32'h00000080);
		xfer(1'b1, 1'b0, 32'h00000100, 32'h0, 1);
		check("man flash", rd[0], WORD_ZERO);
		check("man flash wait", 32'(waits), 32'h0);
		$display("test window done");
		test_done();
	end
endmodule // test_fqs_ctrl
`default_nettype wire
